// File: logic/cfg_pkg.sv
`default_nettype none
package cfg_pkg;

    // ****************************************
    // bus geometry and register map
    // ****************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_SLEEP = 12'h004;
    localparam logic [11:0] OFF_TXPWR = 12'h008;
    localparam logic [11:0] OFF_APPEAR = 12'h00c;
    localparam logic [11:0] OFF_NAME_LEN = 12'h010;
    localparam logic [11:0] OFF_STATUS = 12'h014;
    localparam logic [11:0] OFF_LE_NAME = 12'h100;
    localparam logic [11:0] OFF_CL_NAME = 12'h200;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTRL_USER_ADV_BIT = 0;
    localparam int CTRL_PWM_BIT = 1;
    localparam int CTRL_INVERT_BIT = 2;
    localparam int SLEEP_SYS_LSB = 0;
    localparam int SLEEP_PIPE_LSB = 8;
    localparam int NAME_CL_LSB = 16;
    localparam int TXP_DBM_LSB = 8;
    localparam int STATUS_AWAKE_BIT = 2;
    localparam int STATUS_DEEP_BIT = 3;

    // ****************************************
    // limits, levels and reset values
    // ****************************************
    localparam logic [6:0] NAME_MAX = 7'h40;
    localparam logic [4:0] SCAN_NAME_MAX = 5'h1d;
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_NORMAL = 2'h1;
    localparam logic [1:0] LVL_DEEP = 2'h2;
    localparam logic [1:0] SYS_LEVEL_RST = 2'h1;
    localparam logic [1:0] PIPE_LEVEL_RST = 2'h1;
    localparam logic [2:0] TXP_MIN = 3'h1;
    localparam logic [2:0] TXP_MAX = 3'h7;
    localparam logic [2:0] TXP_RST = 3'h7;
    localparam int DBM_BASE = -16;
    localparam int DBM_STEP = 4;
    localparam logic signed [5:0] DBM_RST = 6'h08;
    localparam logic [15:0] APPEAR_RST = 16'h0000;
    localparam logic [7:0] CL_TAG0 = 8'h42;
    localparam logic [7:0] CL_TAG1 = 8'h54;
    localparam logic [6:0] CL_LEN_RST = 7'h02;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic [9:0] category;
        logic [5:0] sub;
    } appearance_t;

    typedef struct packed {
        logic [2:0] index;
        logic signed [5:0] dbm;
        logic apply;
    } radio_cfg_t;

    typedef struct packed {
        logic [1:0] level;
        logic sleep_now;
        logic normal_sleep_state;
        logic deep_sleep_state;
        logic uart_rx_ready;
    } power_t;

endpackage

`default_nettype wire

// File: logic/level_min.sv
`timescale 1ns/1ps
`default_nettype none

// smaller of two sleep levels
module level_min (
    input wire logic [1:0] a,
    input wire logic [1:0] b,
    output logic [1:0] y
);
    assign y = (a < b) ? a : b;
endmodule // level_min

`default_nettype wire

// File: logic/sleep_radio_cfg.sv
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - name lengths above 64 bytes are refused; stored names stay unchanged
// - scan response carries at most the first 29 name bytes
// - separate low-energy and classic names; classic starts with two-letter tag
// - appearance is 16 bits: 10-bit category plus 6-bit subfield
// - name and appearance apply at once; scan copy frozen under user advertising
// - power index 1..7 maps to -16..+8 dBm in 4 dB steps, reset 7
// - a new power index reaches the radio immediately
// - permit pin high keeps the device active whatever the limits, except once deep sleep is already held
// - otherwise effective level is the smallest applicable limit, 0/1/2
// - pipe limit counts only while pipe connected and in data mode
// - high-resolution pwm forces level 0
// - after reset system limit is 1; pin high means awake
// - deep sleep holds until restart; normal sleep may miss serial input
// - sleep is entered in gaps between radio events when level allows
// - on one variant the permit pin sense is inverted
module sleep_radio_cfg (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic awvalid,
    output logic awready,
    input wire logic [cfg_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [cfg_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic low_power_permit_pin,
    input wire logic pipe_connected,
    input wire logic pipe_data_mode,
    input wire logic radio_gap,
    output cfg_pkg::radio_cfg_t radio_cfg,
    output cfg_pkg::power_t power,
    output cfg_pkg::appearance_t gatt_appearance,
    output logic [63:0][7:0] gatt_le_name,
    output logic [6:0] gatt_le_len,
    output logic [63:0][7:0] classic_name,
    output logic [6:0] classic_len,
    output logic [28:0][7:0] scan_name,
    output logic [4:0] scan_len,
    output logic scan_update
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic aw_got;
        logic [cfg_pkg::ADDR_W-1:0] awaddr;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic user_adv;
        logic pwm_hires;
        logic permit_invert;
        logic [1:0] sys_level;
        logic [1:0] pipe_level;
        cfg_pkg::radio_cfg_t radio;
        cfg_pkg::appearance_t appear;
        logic [63:0][7:0] le_name;
        logic [6:0] le_len;
        logic [63:0][7:0] cl_name;
        logic [6:0] cl_len;
        logic [28:0][7:0] scan_name;
        logic [4:0] scan_len;
        logic scan_update;
        logic deep_hold;
        cfg_pkg::power_t pwr;
    } state_t;

    state_t st_ff;
    state_t nxt_st;

    logic permit_sync;
    logic permit_awake;
    logic pipe_open;
    logic [1:0] pipe_lim;
    logic [1:0] pwm_lim;
    logic [1:0] min_sys_pipe;
    logic [1:0] min_all;
    logic [1:0] eff_level;
    logic [31:0] wv;
    logic refresh;
    logic [cfg_pkg::ADDR_W-1:0] wa;
    logic [cfg_pkg::ADDR_W-1:0] ra;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction

    // ****************************************
    // sleep level selection
    // ****************************************
    sync2 u_permit_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .d(low_power_permit_pin),
        .q(permit_sync)
    );

    assign permit_awake = permit_sync ^ st_ff.permit_invert;
    assign pipe_open = pipe_connected && pipe_data_mode;
    assign pipe_lim = pipe_open ? st_ff.pipe_level : cfg_pkg::LVL_DEEP;
    assign pwm_lim = st_ff.pwm_hires ? cfg_pkg::LVL_NONE : cfg_pkg::LVL_DEEP;

    level_min u_min_sys_pipe (
        .a(st_ff.sys_level),
        .b(pipe_lim),
        .y(min_sys_pipe)
    );

    level_min u_min_pwm (
        .a(min_sys_pipe),
        .b(pwm_lim),
        .y(min_all)
    );

    assign eff_level = permit_awake ? cfg_pkg::LVL_NONE : min_all;

    // ****************************************
    // bus handshakes
    // ****************************************
    assign awready = !st_ff.aw_got && !st_ff.bvalid;
    assign wready = !st_ff.w_got && !st_ff.bvalid;
    assign arready = !st_ff.rvalid;
    assign wa = {st_ff.awaddr[cfg_pkg::ADDR_W-1:2], 2'h0};
    assign ra = {araddr[cfg_pkg::ADDR_W-1:2], 2'h0};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        nxt_st = st_ff;
        wv = 32'h0;
        refresh = 1'b0;
        nxt_st.radio.apply = 1'b0;
        nxt_st.scan_update = 1'b0;

        if (awvalid && awready) begin
            nxt_st.aw_got = 1'b1;
            nxt_st.awaddr = awaddr;
        end
        if (wvalid && wready) begin
            nxt_st.w_got = 1'b1;
            nxt_st.wdata = wdata;
            nxt_st.wstrb = wstrb;
        end
        if (st_ff.bvalid && bready) begin
            nxt_st.bvalid = 1'b0;
        end

        // a write executes one cycle after both halves are held
        if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
            nxt_st.aw_got = 1'b0;
            nxt_st.w_got = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp = cfg_pkg::RESP_OKAY;
            if (wa[cfg_pkg::ADDR_W-1:6] == cfg_pkg::OFF_LE_NAME[cfg_pkg::ADDR_W-1:6]) begin
                for (int b = 0; b < 4; b++) begin
                    if (st_ff.wstrb[b]) begin
                        nxt_st.le_name[6'({wa[5:2], 2'(b)})] = st_ff.wdata[8*b +: 8];
                    end
                end
                refresh = 1'b1;
            end else if (wa[cfg_pkg::ADDR_W-1:6] == cfg_pkg::OFF_CL_NAME[cfg_pkg::ADDR_W-1:6]) begin
                for (int b = 0; b < 4; b++) begin
                    if (st_ff.wstrb[b]) begin
                        nxt_st.cl_name[6'({wa[5:2], 2'(b)})] = st_ff.wdata[8*b +: 8];
                    end
                end
            end else begin
                case (wa)
                    cfg_pkg::OFF_CTRL: begin
                        wv = merge({29'h0, st_ff.permit_invert, st_ff.pwm_hires, st_ff.user_adv},
                                   st_ff.wdata, st_ff.wstrb);
                        nxt_st.user_adv = wv[cfg_pkg::CTRL_USER_ADV_BIT];
                        nxt_st.pwm_hires = wv[cfg_pkg::CTRL_PWM_BIT];
                        nxt_st.permit_invert = wv[cfg_pkg::CTRL_INVERT_BIT];
                        // leaving user advertising puts the managed name back
                        if (st_ff.user_adv && !nxt_st.user_adv) begin
                            refresh = 1'b1;
                        end
                    end
                    cfg_pkg::OFF_SLEEP: begin
                        wv = merge({22'h0, st_ff.pipe_level, 6'h0, st_ff.sys_level}, st_ff.wdata, st_ff.wstrb);
                        if (wv[cfg_pkg::SLEEP_SYS_LSB +: 2] > cfg_pkg::LVL_DEEP ||
                            wv[cfg_pkg::SLEEP_PIPE_LSB +: 2] > cfg_pkg::LVL_DEEP) begin
                            nxt_st.bresp = cfg_pkg::RESP_SLVERR;
                        end else begin
                            nxt_st.sys_level = wv[cfg_pkg::SLEEP_SYS_LSB +: 2];
                            nxt_st.pipe_level = wv[cfg_pkg::SLEEP_PIPE_LSB +: 2];
                        end
                    end
                    cfg_pkg::OFF_TXPWR: begin
                        wv = merge({29'h0, st_ff.radio.index}, st_ff.wdata, st_ff.wstrb);
                        if (wv[7:0] < 8'(cfg_pkg::TXP_MIN) || wv[7:0] > 8'(cfg_pkg::TXP_MAX)) begin
                            nxt_st.bresp = cfg_pkg::RESP_SLVERR;
                        end else begin
                            nxt_st.radio.index = wv[2:0];
                            nxt_st.radio.dbm = 6'(cfg_pkg::DBM_BASE +
                                                  cfg_pkg::DBM_STEP * (int'(wv[2:0]) - 1));
                            nxt_st.radio.apply = 1'b1;
                        end
                    end
                    cfg_pkg::OFF_APPEAR: begin
                        wv = merge({16'h0, st_ff.appear}, st_ff.wdata, st_ff.wstrb);
                        nxt_st.appear = wv[15:0];
                    end
                    cfg_pkg::OFF_NAME_LEN: begin
                        wv = merge({9'h0, st_ff.cl_len, 9'h0, st_ff.le_len}, st_ff.wdata, st_ff.wstrb);
                        if (wv[6:0] > cfg_pkg::NAME_MAX || wv[cfg_pkg::NAME_CL_LSB +: 7] > cfg_pkg::NAME_MAX) begin
                            nxt_st.bresp = cfg_pkg::RESP_SLVERR;
                        end else begin
                            nxt_st.le_len = wv[6:0];
                            nxt_st.cl_len = wv[cfg_pkg::NAME_CL_LSB +: 7];
                            refresh = 1'b1;
                        end
                    end
                    cfg_pkg::OFF_STATUS: begin
                    end
                    default: begin
                        nxt_st.bresp = cfg_pkg::RESP_DECERR;
                    end
                endcase
            end
        end

        // scan copy follows the name only while content is managed here
        if (refresh && !nxt_st.user_adv) begin
            for (int i = 0; i < 29; i++) begin
                nxt_st.scan_name[i] = nxt_st.le_name[i];
            end
            nxt_st.scan_len = (nxt_st.le_len > 7'(cfg_pkg::SCAN_NAME_MAX)) ? cfg_pkg::SCAN_NAME_MAX
                              : nxt_st.le_len[4:0];
            nxt_st.scan_update = 1'b1;
        end

        // reads answer the cycle after the address is taken
        if (st_ff.rvalid && rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp = cfg_pkg::RESP_OKAY;
            nxt_st.rdata = 32'h0;
            if (ra[cfg_pkg::ADDR_W-1:6] == cfg_pkg::OFF_LE_NAME[cfg_pkg::ADDR_W-1:6]) begin
                for (int b = 0; b < 4; b++) begin
                    nxt_st.rdata[8*b +: 8] = st_ff.le_name[6'({ra[5:2], 2'(b)})];
                end
            end else if (ra[cfg_pkg::ADDR_W-1:6] == cfg_pkg::OFF_CL_NAME[cfg_pkg::ADDR_W-1:6]) begin
                for (int b = 0; b < 4; b++) begin
                    nxt_st.rdata[8*b +: 8] = st_ff.cl_name[6'({ra[5:2], 2'(b)})];
                end
            end else begin
                case (ra)
                    cfg_pkg::OFF_CTRL: nxt_st.rdata = {29'h0, st_ff.permit_invert, st_ff.pwm_hires, st_ff.user_adv};
                    cfg_pkg::OFF_SLEEP: nxt_st.rdata = {22'h0, st_ff.pipe_level, 6'h0, st_ff.sys_level};
                    cfg_pkg::OFF_TXPWR: nxt_st.rdata = {18'h0, st_ff.radio.dbm, 5'h0, st_ff.radio.index};
                    cfg_pkg::OFF_APPEAR: nxt_st.rdata = {16'h0, st_ff.appear};
                    cfg_pkg::OFF_NAME_LEN: nxt_st.rdata = {9'h0, st_ff.cl_len, 9'h0, st_ff.le_len};
                    cfg_pkg::OFF_STATUS: nxt_st.rdata = {28'h0, st_ff.deep_hold, permit_awake, st_ff.pwr.level};
                    default: nxt_st.rresp = cfg_pkg::RESP_DECERR;
                endcase
            end
        end

        // power state; deep sleep is left only through reset
        nxt_st.pwr.level = eff_level;
        if (eff_level == cfg_pkg::LVL_DEEP && radio_gap) begin
            nxt_st.deep_hold = 1'b1;
        end
        nxt_st.pwr.sleep_now = nxt_st.deep_hold || (eff_level != cfg_pkg::LVL_NONE && radio_gap);
        nxt_st.pwr.deep_sleep_state = nxt_st.deep_hold;
        nxt_st.pwr.normal_sleep_state = nxt_st.pwr.sleep_now && !nxt_st.deep_hold;
        nxt_st.pwr.uart_rx_ready = !nxt_st.pwr.sleep_now;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '0;
            st_ff.sys_level <= cfg_pkg::SYS_LEVEL_RST;
            st_ff.pipe_level <= cfg_pkg::PIPE_LEVEL_RST;
            st_ff.radio.index <= cfg_pkg::TXP_RST;
            st_ff.radio.dbm <= cfg_pkg::DBM_RST;
            st_ff.appear <= cfg_pkg::APPEAR_RST;
            st_ff.cl_name[0] <= cfg_pkg::CL_TAG0;
            st_ff.cl_name[1] <= cfg_pkg::CL_TAG1;
            st_ff.cl_len <= cfg_pkg::CL_LEN_RST;
            st_ff.pwr.uart_rx_ready <= 1'b1;
        end else if (ce) begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign bvalid = st_ff.bvalid;
    assign bresp = st_ff.bresp;
    assign rvalid = st_ff.rvalid;
    assign rdata = st_ff.rdata;
    assign rresp = st_ff.rresp;
    assign radio_cfg = st_ff.radio;
    assign power = st_ff.pwr;
    assign gatt_appearance = st_ff.appear;
    assign gatt_le_name = st_ff.le_name;
    assign gatt_le_len = st_ff.le_len;
    assign classic_name = st_ff.cl_name;
    assign classic_len = st_ff.cl_len;
    assign scan_name = st_ff.scan_name;
    assign scan_len = st_ff.scan_len;
    assign scan_update = st_ff.scan_update;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    permit_awake_a: assert property (ce && permit_awake |=> st_ff.pwr.level == cfg_pkg::LVL_NONE)
        else $error("permit pin did not keep level at none");
    pwm_force_a: assert property (ce && st_ff.pwm_hires |=> st_ff.pwr.level == cfg_pkg::LVL_NONE)
        else $error("pwm did not force level none");
    sys_limit_a: assert property (ce |=> st_ff.pwr.level <= $past(st_ff.sys_level))
        else $error("level above system limit");
    pipe_limit_a: assert property (ce && pipe_open |=> st_ff.pwr.level <= $past(st_ff.pipe_level))
        else $error("level above pipe limit while pipe open");
    txp_range_a: assert property (st_ff.radio.index >= cfg_pkg::TXP_MIN &&
                                  st_ff.radio.dbm == 6'(cfg_pkg::DBM_BASE +
                                  cfg_pkg::DBM_STEP * (int'(st_ff.radio.index) - 1)))
        else $error("power index out of range or dbm mismatch");
    tx_apply_a: assert property (ce && nxt_st.radio.index != st_ff.radio.index |=> st_ff.radio.apply)
        else $error("new power index not applied");
    name_len_a: assert property (st_ff.le_len <= cfg_pkg::NAME_MAX && st_ff.cl_len <= cfg_pkg::NAME_MAX)
        else $error("stored name longer than limit");
    scan_len_a: assert property (ce && st_ff.scan_update |-> st_ff.scan_len <= cfg_pkg::SCAN_NAME_MAX)
        else $error("scan name longer than limit");
    scan_frozen_a: assert property (ce && st_ff.user_adv && nxt_st.user_adv |=> $stable(st_ff.scan_len))
        else $error("scan name changed under user advertising");
    deep_hold_a: assert property (ce && st_ff.deep_hold |=> st_ff.deep_hold && !st_ff.pwr.uart_rx_ready)
        else $error("deep sleep left before reset");

    deep_entry_c: cover property (st_ff.pwr.level == cfg_pkg::LVL_DEEP ##1 st_ff.deep_hold);
    tx_change_c: cover property (st_ff.radio.apply);
    reject_c: cover property (st_ff.bvalid && st_ff.bresp == cfg_pkg::RESP_SLVERR);
    normal_gap_c: cover property (st_ff.pwr.normal_sleep_state);

endmodule // sleep_radio_cfg

`default_nettype wire

// File: logic/sync2.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for a level from outside the clock domain
module sync2 (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic [1:0] sync_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_ff <= 2'h0;
        end else if (ce) begin
            sync_ff <= {sync_ff[0], d};
        end
    end

    assign q = sync_ff[1];
endmodule // sync2

`default_nettype wire

// File: verif/sleep_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side: permit pin, pipe status, radio gaps
// ****************************************
module sleep_host_model (
    input wire logic want_awake,
    input wire logic invert,
    input wire logic pipe_open,
    input wire logic gap,
    output logic low_power_permit_pin,
    output logic pipe_connected,
    output logic pipe_data_mode,
    output logic radio_gap
);
    // the inverted-pin variant must flip the sense on this side as well
    assign low_power_permit_pin = want_awake ^ invert;
    assign pipe_connected = pipe_open;
    assign pipe_data_mode = pipe_open;
    assign radio_gap = gap;
endmodule // sleep_host_model
`default_nettype wire

// File: verif/sleep_radio_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sleep_radio_cfg_bench;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rv;
    logic [1:0] bresp, rresp, r;
    logic want_awake, invert, pipe_open, gap, pin, pconn, pmode, rgap;
    cfg_pkg::radio_cfg_t rc;
    cfg_pkg::power_t pw;
    cfg_pkg::appearance_t ap;
    logic [63:0][7:0] le_nm;
    logic [28:0][7:0] sc_nm;
    logic [6:0] le_len;
    logic [4:0] sc_len;
    logic scan_upd, su, tx_ap;
    int err_count, checked;

    sleep_host_model host (.want_awake(want_awake), .invert(invert), .pipe_open(pipe_open), .gap(gap),
        .low_power_permit_pin(pin), .pipe_connected(pconn), .pipe_data_mode(pmode), .radio_gap(rgap));
    sleep_radio_cfg DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
        .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .low_power_permit_pin(pin),
        .pipe_connected(pconn), .pipe_data_mode(pmode), .radio_gap(rgap), .radio_cfg(rc), .power(pw),
        .gatt_appearance(ap), .gatt_le_name(le_nm), .gatt_le_len(le_len), .classic_name(),
        .classic_len(), .scan_name(sc_nm), .scan_len(sc_len), .scan_update(scan_upd));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    // ****************************************
    // bus tasks and comparison
    // ****************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // a wait that ran out is a mismatch and ends the run
    task automatic hang(input int n);
        if (n >= 64) begin
            chk(32'hdead, 32'h0);
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1 && n < 64);
        hang(n);
        r = bresp;
        // both pulses stand in the same cycle as bvalid
        su = scan_upd;
        tx_ap = rc.apply;
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] a);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1 && n < 64);
        hang(n);
        rv = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    // covers the pin synchroniser plus the registered level
    task automatic settle();
        repeat (5) @(posedge aclk);
    endtask

    task automatic t_reset();
        rd(cfg_pkg::OFF_SLEEP); chk(rv, 32'h0000_0101);
        rd(cfg_pkg::OFF_TXPWR); chk(rv, 32'h0000_0807);
        rd(cfg_pkg::OFF_NAME_LEN); chk(rv, 32'h0002_0000);
        rd(cfg_pkg::OFF_CL_NAME); chk(rv[15:0], 16'h5442);
        chk(pw.level, 32'h0);
        $display("reset test done");
    endtask

    task automatic t_txpwr();
        for (int i = 7; i >= 1; i--) begin
            wr(cfg_pkg::OFF_TXPWR, 32'(i)); chk(rc.index, 32'(i));
            chk(32'(tx_ap), 32'h1);
            chk({26'h0, rc.dbm}, {26'h0, 6'(-16 + 4 * (i - 1))});
        end
        wr(cfg_pkg::OFF_TXPWR, 32'h0); chk(r, cfg_pkg::RESP_SLVERR);
        wr(cfg_pkg::OFF_TXPWR, 32'h8); chk(r, cfg_pkg::RESP_SLVERR);
        chk(32'(tx_ap), 32'h0);
        chk(rc.index, 32'h1);
        $display("tx power test done");
    endtask

    task automatic t_name();
        wr(cfg_pkg::OFF_NAME_LEN, 32'h0002_0041); chk(r, cfg_pkg::RESP_SLVERR);
        for (int k = 0; k < 10; k++) begin
            wr(cfg_pkg::OFF_LE_NAME + 12'(4 * k), {8'(4 * k + 4), 8'(4 * k + 3), 8'(4 * k + 2), 8'(4 * k + 1)});
        end
        wr(cfg_pkg::OFF_NAME_LEN, 32'h0002_0028); chk(le_len, 32'h28);
        chk(sc_len, 32'h1d);
        chk(32'(su), 32'h1);
        chk(sc_nm[28], 32'h1d);
        chk(le_nm[39], 32'h28);
        wr(cfg_pkg::OFF_CTRL, 32'h1);
        wr(cfg_pkg::OFF_NAME_LEN, 32'h0002_0010); chk(le_len, 32'h10);
        chk(32'(su), 32'h0);
        chk(sc_len, 32'h1d);
        wr(cfg_pkg::OFF_CTRL, 32'h0); chk(sc_len, 32'h10);
        $display("name test done");
    endtask

    task automatic t_appear();
        wr(cfg_pkg::OFF_APPEAR, 32'h0080); chk(ap.category, 32'h2);
        chk(ap.sub, 32'h0);
        wr(cfg_pkg::OFF_APPEAR, 32'hffff); rd(cfg_pkg::OFF_APPEAR); chk(rv, 32'hffff);
        rd(12'h800); chk(r, cfg_pkg::RESP_DECERR);
        wr(12'h800, 32'h1); chk(r, cfg_pkg::RESP_DECERR);
        $display("appearance test done");
    endtask

    task automatic t_sleep();
        wr(cfg_pkg::OFF_SLEEP, 32'h0000_0102); settle(); chk(pw.level, 32'h0);
        want_awake <= 1'b0; settle(); chk(pw.level, 32'h2);
        pipe_open <= 1'b1; settle(); chk(pw.level, 32'h1);
        wr(cfg_pkg::OFF_CTRL, 32'h2); settle(); chk(pw.level, 32'h0);
        wr(cfg_pkg::OFF_CTRL, 32'h0);
        wr(cfg_pkg::OFF_SLEEP, 32'h0000_0103); chk(r, cfg_pkg::RESP_SLVERR);
        settle(); chk(pw.level, 32'h1);
        gap <= 1'b1; settle(); chk({pw.sleep_now, pw.normal_sleep_state, pw.uart_rx_ready}, 32'h6);
        wr(cfg_pkg::OFF_CTRL, 32'h4);
        invert <= 1'b1;
        want_awake <= 1'b1; settle(); chk(pw.level, 32'h0);
        wr(cfg_pkg::OFF_CTRL, 32'h0);
        invert <= 1'b0;
        want_awake <= 1'b0;
        pipe_open <= 1'b0; settle(); chk({pw.deep_sleep_state, pw.sleep_now}, 32'h3);
        $display("sleep test done");
    endtask

    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, invert, pipe_open, gap} = '0;
        {awaddr, araddr, wdata} = '0;
        want_awake = 1'b1;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_txpwr();
        t_name();
        t_appear();
        t_sleep();
        report_and_stop();
    end
endmodule // sleep_radio_cfg_bench
`default_nettype wire
